// *** inc/ofs_params.svh ***
// register offsets, field positions and reset values of the output format block
`ifndef OFS_PARAMS_SVH
`define OFS_PARAMS_SVH
`define OFS_ADDR_W        12
`define OFS_ADDR_CTL2     12'h55a
`define OFS_ADDR_FMT      12'h561
`define OFS_ADDR_ORCLR    12'h562
`define OFS_ADDR_ORSTAT   12'h563
`define OFS_ADDR_CHSEL    12'h564
`define OFS_ADDR_RATE     12'h56e
`define OFS_ADDR_PLL      12'h56f
`define OFS_ADDR_QUICK    12'h570
`define OFS_ADDR_IRQSTAT  12'h5f0
`define OFS_ADDR_IRQMASK  12'h5f1
`define OFS_RST_CTL2      8'h01
`define OFS_RST_FMT       8'h01
`define OFS_RST_ORCLR     8'h00
`define OFS_RST_CHSEL     8'h00
`define OFS_RST_RATE      8'h10
`define OFS_RST_QUICK     8'h88
`define OFS_RST_IRQMASK   8'h00
`define OFS_FMT_INV_BIT   2
`define OFS_RATE_BIT      4
`define OFS_PLL_BIT       7
`define OFS_IRQ_OR_BIT    0
`define OFS_IRQ_LOCK_BIT  1
`define OFS_IRQ_UNLK_BIT  2
`define OFS_SAMPLE_W      14
`define OFS_NUM_VC        8
`endif

// *** inc/ofs_pkg.sv ***
// types shared by the output format block
package ofs_pkg;
    typedef enum logic [1:0] {OFS_FMT_OFFSET_BIN, OFS_FMT_TWOS_COMP, OFS_FMT_RSV2, OFS_FMT_RSV3}
        ofs_fmt_e;
    typedef struct packed {
        logic [13:0] ch_a;
        logic [13:0] ch_b;
    } ofs_pair_s;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } ofs_bus_s;
endpackage : ofs_pkg

// *** hw/ofs_sample_fmt.sv ***
// per-sample format conversion, inversion and channel swap
`include "ofs_params.svh"
module ofs_sample_fmt
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [1:0]        fmt_sel,
    input  wire logic              invert,
    input  wire logic              swap,
    input  wire ofs_pkg::ofs_pair_s in_pair,
    output      ofs_pkg::ofs_pair_s out_pair
);
    import ofs_pkg::*;

    function automatic logic [13:0] conv(input logic [13:0] s, input logic [1:0] f,
                                         input logic inv);
        logic [13:0] t;
        t = inv ? ~s : s;
        if (f == 2'(OFS_FMT_OFFSET_BIN))
            conv = {~t[13], t[12:0]};
        else
            conv = t;
    endfunction : conv

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            out_pair <= '0;
        else if (swap)
        begin
            out_pair.ch_a <= conv(in_pair.ch_b, fmt_sel, invert);
            out_pair.ch_b <= conv(in_pair.ch_a, fmt_sel, invert);
        end
        else
        begin
            out_pair.ch_a <= conv(in_pair.ch_a, fmt_sel, invert);
            out_pair.ch_b <= conv(in_pair.ch_b, fmt_sel, invert);
        end
    end
endmodule : ofs_sample_fmt

// *** hw/ofs_regs.sv ***
// output format and status register bank
`include "ofs_params.svh"
module ofs_regs
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire ofs_pkg::ofs_bus_s  bus,
    output      logic [7:0]         rdata,
    input  wire logic [7:0]         vc_overrange,
    input  wire logic               pll_locked_async,
    input  wire ofs_pkg::ofs_pair_s sample_in,
    output      ofs_pkg::ofs_pair_s sample_out,
    output      logic               low_rate_band,
    output      logic [7:0]         quick_setup,
    output      logic [7:0]         ctl_select_2,
    output      logic               irq
);
    import ofs_pkg::*;

    // ==========================================================
    // control registers
    logic [7:0] fmt_q;
    logic [7:0] orclr_q;
    logic [7:0] chsel_q;
    logic [7:0] rate_q;
    logic [7:0] quick_q;
    logic [7:0] ctl2_q;
    logic [7:0] mask_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fmt_q   <= `OFS_RST_FMT;
            orclr_q <= `OFS_RST_ORCLR;
            chsel_q <= `OFS_RST_CHSEL;
            rate_q  <= `OFS_RST_RATE;
            quick_q <= `OFS_RST_QUICK;
            ctl2_q  <= `OFS_RST_CTL2;
            mask_q  <= `OFS_RST_IRQMASK;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                `OFS_ADDR_FMT:     fmt_q   <= {5'h00, bus.wdata[2:0]};
                `OFS_ADDR_ORCLR:   orclr_q <= bus.wdata;
                `OFS_ADDR_CHSEL:   chsel_q <= {7'h00, bus.wdata[0]};
                `OFS_ADDR_RATE:    rate_q  <= {3'h0, bus.wdata[4], 4'h0};
                `OFS_ADDR_QUICK:   quick_q <= bus.wdata;
                `OFS_ADDR_CTL2:    ctl2_q  <= {5'h00, bus.wdata[2:0]};
                `OFS_ADDR_IRQMASK: mask_q  <= {5'h00, bus.wdata[2:0]};
                default:           ;
            endcase
        end
    end

    // ==========================================================
    // lock synchroniser
    logic sync1_q;
    logic lock_q;
    logic lock_prev_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync1_q     <= 1'b0;
            lock_q      <= 1'b0;
            lock_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q     <= pll_locked_async;
            lock_q      <= sync1_q;
            lock_prev_q <= lock_q;
        end
    end

    // ==========================================================
    // overrange flags, one per virtual converter
    logic [7:0] or_q;
    genvar g;
    generate
        for (g = 0; g < `OFS_NUM_VC; g++)
        begin : g_or
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    or_q[g] <= 1'b0;
                else if (vc_overrange[g])
                    or_q[g] <= 1'b1;
                else if (orclr_q[g])
                    or_q[g] <= 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // interrupt status, cleared by read, set wins
    logic [7:0] ev;
    logic [7:0] irqs_q;
    logic       rd_irqs;
    assign ev = {5'h00, lock_prev_q & ~lock_q, lock_q & ~lock_prev_q, |(vc_overrange & ~orclr_q)};
    assign rd_irqs = bus.rd && bus.addr == `OFS_ADDR_IRQSTAT;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irqs_q <= 8'h00;
        else
            irqs_q <= (rd_irqs ? 8'h00 : irqs_q) | ev;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |((ev | (rd_irqs ? 8'h00 : irqs_q)) & mask_q);
    end

    // ==========================================================
    // read port
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (bus.rd)
        begin
            case (bus.addr)
                `OFS_ADDR_FMT:     rdata <= fmt_q;
                `OFS_ADDR_ORCLR:   rdata <= orclr_q;
                `OFS_ADDR_ORSTAT:  rdata <= or_q;
                `OFS_ADDR_CHSEL:   rdata <= chsel_q;
                `OFS_ADDR_RATE:    rdata <= rate_q;
                `OFS_ADDR_PLL:     rdata <= {lock_q, 7'h00};
                `OFS_ADDR_QUICK:   rdata <= quick_q;
                `OFS_ADDR_CTL2:    rdata <= ctl2_q;
                `OFS_ADDR_IRQSTAT: rdata <= irqs_q;
                `OFS_ADDR_IRQMASK: rdata <= mask_q;
                default:           rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    // ==========================================================
    // outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            low_rate_band <= 1'b0;
            quick_setup   <= `OFS_RST_QUICK;
            ctl_select_2  <= `OFS_RST_CTL2;
        end
        else
        begin
            low_rate_band <= rate_q[`OFS_RATE_BIT];
            quick_setup   <= quick_q;
            ctl_select_2  <= ctl2_q;
        end
    end

    ofs_sample_fmt u_fmt
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .fmt_sel  (fmt_q[1:0]),
        .invert   (fmt_q[`OFS_FMT_INV_BIT]),
        .swap     (chsel_q[0]),
        .in_pair  (sample_in),
        .out_pair (sample_out)
    );

    // ==========================================================
    // checks
    sequence s_write(logic [11:0] a);
        bus.wr && bus.addr == a;
    endsequence

    sequence s_read(logic [11:0] a);
        bus.rd && bus.addr == a;
    endsequence

    sequence s_write_then_read(logic [11:0] a);
        s_write(a) ##1 !bus.wr ##1 s_read(a);
    endsequence

    a_or_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        vc_overrange[0] |=> or_q[0])
        else $error("overrange flag not set");

    a_or_clear: assert property (@(posedge sys_clk) disable iff (rst)
        orclr_q[1] && !vc_overrange[1] |=> !or_q[1])
        else $error("flag not cleared");

    a_or_hold: assert property (@(posedge sys_clk) disable iff (rst)
        or_q[2] && !orclr_q[2] |=> or_q[2])
        else $error("flag lost");

    a_or_all_set: assert property (@(posedge sys_clk) disable iff (rst)
        |vc_overrange |=> (or_q & $past(vc_overrange)) == $past(vc_overrange))
        else $error("overrange event not recorded");

    a_or_all_clear: assert property (@(posedge sys_clk) disable iff (rst)
        |(orclr_q & ~vc_overrange) |=> (or_q & $past(orclr_q & ~vc_overrange)) == 8'h00)
        else $error("cleared flag still set");

    a_or_no_spur: assert property (@(posedge sys_clk) disable iff (rst)
        !(|vc_overrange) |=> (or_q & ~$past(or_q)) == 8'h00)
        else $error("flag set without event");

    a_orstat_read: assert property (@(posedge sys_clk) disable iff (rst)
        s_read(`OFS_ADDR_ORSTAT) |=> rdata == $past(or_q))
        else $error("overrange status read wrong");

    a_pll_read: assert property (@(posedge sys_clk) disable iff (rst)
        s_read(`OFS_ADDR_PLL) |=>
        rdata == {$past(lock_q), 7'h00})
        else $error("pll status wrong");

    a_pll_low_zero: assert property (@(posedge sys_clk) disable iff (rst)
        s_read(`OFS_ADDR_PLL) |=> rdata[6:0] == 7'h00)
        else $error("pll status low bits set");

    a_lock_path: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(sync1_q) |=> lock_q)
        else $error("lock not passed");

    a_lock_drop: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(sync1_q) |=> !lock_q)
        else $error("lock loss not passed");

    a_fmt_store: assert property (@(posedge sys_clk) disable iff (rst)
        s_write(`OFS_ADDR_FMT) |=> fmt_q == {5'h00, $past(bus.wdata[2:0])})
        else $error("format write lost");

    a_fmt_readback: assert property (@(posedge sys_clk) disable iff (rst)
        s_write_then_read(`OFS_ADDR_FMT) |=>
        rdata == {5'h00, $past(bus.wdata[2:0], 3)})
        else $error("format readback wrong");

    a_chsel_store: assert property (@(posedge sys_clk) disable iff (rst)
        s_write(`OFS_ADDR_CHSEL) |=> chsel_q == {7'h00, $past(bus.wdata[0])})
        else $error("channel select write lost");

    a_swap_out: assert property (@(posedge sys_clk) disable iff (rst)
        chsel_q[0] && fmt_q[2:0] == 3'h1 |=> sample_out.ch_a == $past(sample_in.ch_b))
        else $error("swap wrong");

    a_swap_other: assert property (@(posedge sys_clk) disable iff (rst)
        chsel_q[0] && fmt_q[2:0] == 3'h1 |=> sample_out.ch_b == $past(sample_in.ch_a))
        else $error("swap wrong on second channel");

    a_keep_order: assert property (@(posedge sys_clk) disable iff (rst)
        !chsel_q[0] && fmt_q[2:0] == 3'h1 |=>
        sample_out == $past(sample_in))
        else $error("channel order changed");

    a_inv_out: assert property (@(posedge sys_clk) disable iff (rst)
        !chsel_q[0] && fmt_q[2:0] == 3'h5 |=> sample_out.ch_a == ~$past(sample_in.ch_a))
        else $error("invert wrong");

    a_inv_other: assert property (@(posedge sys_clk) disable iff (rst)
        !chsel_q[0] && fmt_q[2:0] == 3'h5 |=> sample_out.ch_b == ~$past(sample_in.ch_b))
        else $error("invert wrong on second channel");

    a_fmt_obin: assert property (@(posedge sys_clk) disable iff (rst)
        !chsel_q[0] && fmt_q[2:0] == 3'h0 |=>
        sample_out.ch_b == {~$past(sample_in.ch_b[13]), $past(sample_in.ch_b[12:0])})
        else $error("offset binary wrong");

    a_rate_store: assert property (@(posedge sys_clk) disable iff (rst)
        s_write(`OFS_ADDR_RATE) |=> rate_q == {3'h0, $past(bus.wdata[4]), 4'h0})
        else $error("rate write lost");

    a_rate_band: assert property (@(posedge sys_clk) disable iff (rst)
        s_write(`OFS_ADDR_RATE) |=> ##1 low_rate_band == $past(bus.wdata[4], 2))
        else $error("rate band wrong");

    a_rate_readback: assert property (@(posedge sys_clk) disable iff (rst)
        s_write_then_read(`OFS_ADDR_RATE) |=>
        rdata == {3'h0, $past(bus.wdata[4], 3), 4'h0})
        else $error("rate readback wrong");

    a_ctl2_out: assert property (@(posedge sys_clk) disable iff (rst)
        s_write(`OFS_ADDR_CTL2) |=> ##1 ctl_select_2 == {5'h00, $past(bus.wdata[2:0], 2)})
        else $error("control select output wrong");

    a_quick_out: assert property (@(posedge sys_clk) disable iff (rst)
        s_write(`OFS_ADDR_QUICK) |=> ##1 quick_setup == $past(bus.wdata, 2))
        else $error("quick setup output wrong");

    a_rd_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data without read");

endmodule : ofs_regs

// *** tb/test_output_format_status_regs.sv ***
// self-checking bench for the output format and status register bank
`include "ofs_params.svh"
module test_output_format_status_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import ofs_pkg::*;
    // ==========================================
    // signals
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    ofs_bus_s    bus = '0;
    logic [7:0]  rdata;
    logic [7:0]  vc_overrange = 8'h00;
    logic        pll_locked_async = 1'b0;
    ofs_pair_s   sample_in = {14'h0123, 14'h2abc};
    ofs_pair_s   sample_out;
    logic        low_rate_band;
    logic        irq;
    logic [7:0]  quick_setup;
    logic [7:0]  ctl_select_2;
    int          miscompares = 0;
    int          cmp_count = 0;
    localparam logic [27:0] MSB2 = {14'h2000, 14'h2000};

    always #12.5 sys_clk = ~sys_clk;

    ofs_regs dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .vc_overrange(vc_overrange), .pll_locked_async(pll_locked_async),
        .sample_in(sample_in), .sample_out(sample_out), .low_rate_band(low_rate_band),
        .quick_setup(quick_setup), .ctl_select_2(ctl_select_2), .irq(irq));
    // ==========================================
    // bus and compare tasks
    task check(input logic [27:0] seen, input logic [27:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            miscompares++;
        end
    endtask : check
    task cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cycles
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task rd_check(input logic [11:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        check(28'(rdata), 28'(e));
    endtask : rd_check
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // ==========================================
    // scenarios
    task test_reset;
        rd_check(`OFS_ADDR_CTL2, 8'h01);
        rd_check(`OFS_ADDR_FMT, 8'h01);
        rd_check(`OFS_ADDR_ORCLR, 8'h00);
        rd_check(`OFS_ADDR_ORSTAT, 8'h00);
        rd_check(`OFS_ADDR_CHSEL, 8'h00);
        rd_check(`OFS_ADDR_RATE, 8'h10);
        rd_check(`OFS_ADDR_PLL, 8'h00);
        rd_check(`OFS_ADDR_QUICK, 8'h88);
        wr(12'h400, 8'hff);
        rd_check(12'h400, 8'h00);
        check(28'({quick_setup, ctl_select_2, low_rate_band, irq}), 28'h22006);
        $display("test_reset done");
    endtask : test_reset
    task test_sample;
        cycles(2);
        check(sample_out, sample_in);
        wr(`OFS_ADDR_FMT, 8'h05);
        cycles(2);
        check(sample_out, ~sample_in);
        rd_check(`OFS_ADDR_FMT, 8'h05);
        wr(`OFS_ADDR_FMT, 8'h00);
        cycles(2);
        check(sample_out, sample_in ^ MSB2);
        wr(`OFS_ADDR_FMT, 8'h04);
        cycles(2);
        check(sample_out, ~sample_in ^ MSB2);
        wr(`OFS_ADDR_FMT, 8'h02);
        rd_check(`OFS_ADDR_FMT, 8'h02);
        check(sample_out, sample_in);
        wr(`OFS_ADDR_FMT, 8'h01);
        wr(`OFS_ADDR_CHSEL, 8'h01);
        cycles(2);
        check(sample_out, {sample_in.ch_b, sample_in.ch_a});
        wr(`OFS_ADDR_CHSEL, 8'h00);
        cycles(2);
        check(sample_out, sample_in);
        $display("test_sample done");
    endtask : test_sample
    task pulse_or(input logic [7:0] v);
        @(posedge sys_clk);
        vc_overrange <= v;
        @(posedge sys_clk);
        vc_overrange <= 8'h00;
    endtask : pulse_or
    task test_overrange;
        pulse_or(8'h87);
        rd_check(`OFS_ADDR_ORSTAT, 8'h87);
        check(28'(irq), 28'h0);
        wr(`OFS_ADDR_IRQMASK, 8'h07);
        cycles(2);
        check(28'(irq), 28'h1);
        rd_check(`OFS_ADDR_IRQSTAT, 8'h01);
        cycles(2);
        check(28'(irq), 28'h0);
        wr(`OFS_ADDR_ORCLR, 8'h03);
        rd_check(`OFS_ADDR_ORSTAT, 8'h84);
        wr(`OFS_ADDR_ORCLR, 8'h00);
        pulse_or(8'h01);
        wr(`OFS_ADDR_ORSTAT, 8'h00);
        rd_check(`OFS_ADDR_ORSTAT, 8'h85);
        rd_check(`OFS_ADDR_IRQSTAT, 8'h01);
        $display("test_overrange done");
    endtask : test_overrange
    task test_link;
        @(posedge sys_clk);
        pll_locked_async <= 1'b1;
        cycles(4);
        rd_check(`OFS_ADDR_PLL, 8'h80);
        rd_check(`OFS_ADDR_IRQSTAT, 8'h02);
        @(posedge sys_clk);
        pll_locked_async <= 1'b0;
        cycles(4);
        rd_check(`OFS_ADDR_PLL, 8'h00);
        rd_check(`OFS_ADDR_IRQSTAT, 8'h04);
        wr(`OFS_ADDR_RATE, 8'h00);
        cycles(2);
        check(28'(low_rate_band), 28'h0);
        wr(`OFS_ADDR_RATE, 8'hff);
        rd_check(`OFS_ADDR_RATE, 8'h10);
        check(28'(low_rate_band), 28'h1);
        wr(`OFS_ADDR_QUICK, 8'h5a);
        cycles(2);
        check(28'(quick_setup), 28'h5a);
        wr(`OFS_ADDR_CTL2, 8'hfd);
        cycles(2);
        check(28'(ctl_select_2), 28'h05);
        rd_check(`OFS_ADDR_CTL2, 8'h05);
        $display("test_link done");
    endtask : test_link
    // ==========================================
    // main sequence and watchdog
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_sample();
        test_overrange();
        test_link();
        end_sim();
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end
endmodule : test_output_format_status_regs
